// ---- logic/uart_net_defs.svh ----
// Register map, field positions, reset values and interrupt codes of the UART network block
`ifndef UART_NET_DEFS_SVH
`define UART_NET_DEFS_SVH

// ==========================================================
// Register byte addresses
`define ADDR_MODEM_STATUS   32'hFFFF0718
`define ADDR_SCRATCH        32'hFFFF071C
`define ADDR_NET_ENABLE     32'hFFFF0720
`define ADDR_NET_IDENT      32'hFFFF0724
`define ADDR_NODE_ADDRESS   32'hFFFF0728
`define ADDR_FRAC_DIVIDER   32'hFFFF072C

// ==========================================================
// Reset values
`define RST_SCRATCH         8'h00
`define RST_NET_ENABLE      8'h04
`define RST_NODE_ADDRESS    8'hAA
`define RST_FRAC_DIVIDER    16'h0000

// ==========================================================
// Network enable fields
`define NE_MODE_ON          7
`define NE_TX9_EN           6
`define NE_RX9_EN           5
`define NE_IRQ_EN           4
`define NE_WORD9_SEL        3
`define NE_DRIVER_EN        2
`define NE_IRQ_POL          1
`define NE_SEND_ADDR        0

// ==========================================================
// Fractional divider fields
`define FD_ENABLE           15
`define FD_M_HI             12
`define FD_M_LO             11
`define FD_N_HI             10
`define FD_N_LO             0
`define FD_M_ZERO_VALUE     3'h4

// ==========================================================
// Interrupt identification codes
`define IC_LINE_STATUS      3'h3
`define IC_ADDR_MATCH       3'h6
`define IC_RX_FULL          3'h2
`define IC_ADDR_SENT        3'h5
`define IC_TX_EMPTY         3'h1
`define IC_MODEM            3'h0

// ==========================================================
// Bus responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ---- logic/uart_net_pkg.sv ----
// Types shared by the UART network block
package uart_net_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] irq_code_t;
    typedef enum logic [2:0] {
        SEL_MODEM,
        SEL_SCRATCH,
        SEL_NET_ENABLE,
        SEL_NET_IDENT,
        SEL_NODE_ADDRESS,
        SEL_FRAC_DIVIDER,
        SEL_NONE
    } reg_sel_e;
endpackage : uart_net_pkg

// ---- logic/uart_net_status.sv ----
// Modem status, scratch, fractional divider and network address logic with AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "uart_net_defs.svh"

module uart_net_status
    import uart_net_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic [31:0] AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [31:0] ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    input  wire logic        CARRIER_DETECT_IN,
    input  wire logic        RING_IN,
    input  wire logic        SET_READY_IN,
    input  wire logic        CLEAR_TO_SEND_IN,
    input  wire logic        LOOPBACK_EN,
    input  wire logic        REQ_TO_SEND_OUT,
    input  wire logic        TERM_READY_OUT,
    input  wire logic        AUX1_OUT,
    input  wire logic        AUX2_OUT,
    input  wire logic        TX_SERIAL_DATA,
    input  wire logic        RX_ADDR_VALID,
    input  wire logic [7:0]  RX_ADDR_BYTE,
    input  wire logic        RX_HOLD_READ,
    input  wire logic        TX_HOLD_WRITE,
    input  wire logic        STD_IDENT_READ,
    input  wire logic        LINE_STATUS_READ,
    input  wire logic        LINE_STATUS_EVT,
    input  wire logic        RX_FULL_EVT,
    input  wire logic        TX_EMPTY_EVT,
    input  wire logic        ADDR_SENT_EVT,
    output logic             SERIAL_OUT_O,
    output logic             SERIAL_OUT_OE,
    output logic             PARITY_CHECK_EN,
    output logic             TX_NINE_BIT_EN,
    output logic             RX_NINE_BIT_EN,
    output logic             NINE_BIT_WORD,
    output logic             TX_ADDRESS_MARK,
    output logic             FRAC_DIV_EN,
    output logic [2:0]       FRAC_M,
    output logic [10:0]      FRAC_N,
    output logic             ADDR_MATCH,
    output logic             NET_IRQ
);

    // ==========================================================
    // Helpers
    function automatic reg_sel_e decode(input logic [31:0] a);
        case (a)
            `ADDR_MODEM_STATUS: decode = SEL_MODEM;
            `ADDR_SCRATCH:      decode = SEL_SCRATCH;
            `ADDR_NET_ENABLE:   decode = SEL_NET_ENABLE;
            `ADDR_NET_IDENT:    decode = SEL_NET_IDENT;
            `ADDR_NODE_ADDRESS: decode = SEL_NODE_ADDRESS;
            `ADDR_FRAC_DIVIDER: decode = SEL_FRAC_DIVIDER;
            default:            decode = SEL_NONE;
        endcase
    endfunction : decode

    function automatic byte_t merge(input byte_t old, input byte_t nw, input logic en);
        merge = en ? nw : old;
    endfunction : merge

    // ==========================================================
    // Modem input synchronisers and loopback
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] lines;
    logic [3:0] lines_prev_q;
    logic [3:0] delta_q;
    logic [3:0] delta_d;

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end
        else
        begin
            sync1_q <= {CARRIER_DETECT_IN, RING_IN, SET_READY_IN, CLEAR_TO_SEND_IN};
            sync2_q <= sync1_q;
        end
    end

    // Bit order: carrier, ring, set ready, clear to send
    always_comb
    begin
        if (LOOPBACK_EN)
            lines = {AUX2_OUT, AUX1_OUT, TERM_READY_OUT, REQ_TO_SEND_OUT};
        else
            lines = sync2_q;
    end

    // ==========================================================
    // AXI4-Lite write channel
    logic        aw_have_q, aw_have_d;
    logic [31:0] aw_addr_q, aw_addr_d;
    logic        w_have_q,  w_have_d;
    logic [31:0] w_data_q,  w_data_d;
    logic [3:0]  w_strb_q,  w_strb_d;
    logic        bvalid_q,  bvalid_d;
    logic [1:0]  bresp_q,   bresp_d;
    logic        do_write;
    reg_sel_e    wsel;

    assign AWREADY  = !aw_have_q && !bvalid_q;
    assign WREADY   = !w_have_q && !bvalid_q;
    assign do_write = aw_have_q && w_have_q && !bvalid_q;
    assign wsel     = decode(aw_addr_q);

    always_comb
    begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (AWVALID && AWREADY)
        begin
            aw_have_d = 1'b1;
            aw_addr_d = AWADDR;
        end
        if (WVALID && WREADY)
        begin
            w_have_d = 1'b1;
            w_data_d = WDATA;
            w_strb_d = WSTRB;
        end
        if (do_write)
        begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end
        if (bvalid_q && BREADY)
            bvalid_d = 1'b0;
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 32'h00000000;
            w_have_q  <= 1'b0;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RESP_OKAY;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q  <= w_have_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    assign BVALID = bvalid_q;
    assign BRESP  = bresp_q;

    // ==========================================================
    // Software registers
    byte_t       scratch_q,   scratch_d;
    byte_t       net_en_q,    net_en_d;
    byte_t       node_addr_q, node_addr_d;
    logic [15:0] frac_q,      frac_d;

    always_comb
    begin
        scratch_d   = scratch_q;
        net_en_d    = net_en_q;
        node_addr_d = node_addr_q;
        frac_d      = frac_q;
        if (do_write)
        begin
            case (wsel)
                SEL_SCRATCH:      scratch_d   = merge(scratch_q, w_data_q[7:0], w_strb_q[0]);
                SEL_NET_ENABLE:   net_en_d    = merge(net_en_q, w_data_q[7:0], w_strb_q[0]);
                SEL_NODE_ADDRESS: node_addr_d = merge(node_addr_q, w_data_q[7:0], w_strb_q[0]);
                SEL_FRAC_DIVIDER:
                begin
                    frac_d[7:0]  = merge(frac_q[7:0], w_data_q[7:0], w_strb_q[0]);
                    frac_d[15:8] = merge(frac_q[15:8], w_data_q[15:8], w_strb_q[1]);
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            scratch_q   <= `RST_SCRATCH;
            net_en_q    <= `RST_NET_ENABLE;
            node_addr_q <= `RST_NODE_ADDRESS;
            frac_q      <= `RST_FRAC_DIVIDER;
        end
        else
        begin
            scratch_q   <= scratch_d;
            net_en_q    <= net_en_d;
            node_addr_q <= node_addr_d;
            frac_q      <= frac_d;
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q,  rdata_d;
    logic [1:0]  rresp_q,  rresp_d;
    logic        rd_take;
    logic        modem_read;
    reg_sel_e    rsel;
    byte_t       ident;

    assign ARREADY    = !rvalid_q;
    assign rd_take    = ARVALID && ARREADY;
    assign rsel       = decode(ARADDR);
    assign modem_read = rd_take && (rsel == SEL_MODEM);

    always_comb
    begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rd_take)
        begin
            rvalid_d = 1'b1;
            rresp_d  = `RESP_OKAY;
            case (rsel)
                SEL_MODEM:        rdata_d = {24'h000000, lines, delta_q};
                SEL_SCRATCH:      rdata_d = {24'h000000, scratch_q};
                SEL_NET_ENABLE:   rdata_d = {24'h000000, net_en_q};
                SEL_NET_IDENT:    rdata_d = {24'h000000, ident};
                SEL_NODE_ADDRESS: rdata_d = {24'h000000, node_addr_q};
                SEL_FRAC_DIVIDER: rdata_d = {16'h0000, frac_q};
                default:
                begin
                    rdata_d = 32'h00000000;
                    rresp_d = `RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_q && RREADY)
            rvalid_d = 1'b0;
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `RESP_OKAY;
        end
        else
        begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    assign RVALID = rvalid_q;
    assign RDATA  = rdata_q;
    assign RRESP  = rresp_q;

    // ==========================================================
    // Delta flags and pending interrupt sources
    logic      mode_on;
    logic      addr_hit;
    logic      line_q,  line_d;
    logic      rxf_q,   rxf_d;
    logic      txe_q,   txe_d;
    logic      match_q, match_d;
    logic      sent_q,  sent_d;
    logic      pending;
    irq_code_t code;

    assign mode_on  = net_en_q[`NE_MODE_ON];
    assign addr_hit = RX_ADDR_VALID && mode_on && net_en_q[`NE_RX9_EN]
                      && (RX_ADDR_BYTE == node_addr_q);

    always_comb
    begin
        delta_d[3] = (delta_q[3] && !modem_read) || (lines[3] != lines_prev_q[3]);
        delta_d[2] = (delta_q[2] && !modem_read) || (lines[2] && !lines_prev_q[2]);
        delta_d[1] = (delta_q[1] && !modem_read) || (lines[1] != lines_prev_q[1]);
        delta_d[0] = (delta_q[0] && !modem_read) || (lines[0] != lines_prev_q[0]);
        line_d  = (line_q && !LINE_STATUS_READ) || LINE_STATUS_EVT;
        rxf_d   = (rxf_q && !RX_HOLD_READ) || RX_FULL_EVT;
        txe_d   = (txe_q && !(TX_HOLD_WRITE || STD_IDENT_READ)) || TX_EMPTY_EVT;
        match_d = (match_q && !RX_HOLD_READ) || addr_hit;
        sent_d  = (sent_q && !(TX_HOLD_WRITE || STD_IDENT_READ))
                  || (ADDR_SENT_EVT && mode_on);
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            lines_prev_q <= 4'h0;
            delta_q      <= 4'h0;
            line_q       <= 1'b0;
            rxf_q        <= 1'b0;
            txe_q        <= 1'b0;
            match_q      <= 1'b0;
            sent_q       <= 1'b0;
        end
        else
        begin
            lines_prev_q <= lines;
            delta_q      <= delta_d;
            line_q       <= line_d;
            rxf_q        <= rxf_d;
            txe_q        <= txe_d;
            match_q      <= match_d;
            sent_q       <= sent_d;
        end
    end

    // ==========================================================
    // Priority encoder and identification value
    always_comb
    begin
        pending = 1'b1;
        if (line_q)
            code = `IC_LINE_STATUS;
        else if (match_q)
            code = `IC_ADDR_MATCH;
        else if (rxf_q)
            code = `IC_RX_FULL;
        else if (sent_q)
            code = `IC_ADDR_SENT;
        else if (txe_q)
            code = `IC_TX_EMPTY;
        else
        begin
            code    = `IC_MODEM;
            pending = |delta_q;
        end
    end

    assign ident = {4'h0, code, !pending};

    // ==========================================================
    // Outputs toward transmitter, receiver, baud generator and pin
    logic serial_q, serial_d;
    logic irq_q,    irq_d;
    logic amatch_q, amatch_d;

    always_comb
    begin
        serial_d = LOOPBACK_EN ? 1'b1 : TX_SERIAL_DATA;
        irq_d    = (mode_on && net_en_q[`NE_IRQ_EN] && pending)
                   == net_en_q[`NE_IRQ_POL];
        amatch_d = addr_hit;
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            serial_q <= 1'b1;
            irq_q    <= 1'b1;
            amatch_q <= 1'b0;
        end
        else
        begin
            serial_q <= serial_d;
            irq_q    <= irq_d;
            amatch_q <= amatch_d;
        end
    end

    assign SERIAL_OUT_O    = serial_q;
    assign SERIAL_OUT_OE   = net_en_q[`NE_DRIVER_EN];
    assign NET_IRQ         = irq_q;
    assign ADDR_MATCH      = amatch_q;
    assign PARITY_CHECK_EN = !mode_on;
    assign TX_NINE_BIT_EN  = mode_on && net_en_q[`NE_TX9_EN];
    assign RX_NINE_BIT_EN  = mode_on && net_en_q[`NE_RX9_EN];
    assign NINE_BIT_WORD   = net_en_q[`NE_WORD9_SEL];
    assign TX_ADDRESS_MARK = mode_on && (scratch_q[0] || net_en_q[`NE_SEND_ADDR]);
    assign FRAC_DIV_EN     = frac_q[`FD_ENABLE];
    assign FRAC_M          = (frac_q[`FD_M_HI:`FD_M_LO] == 2'h0) ? `FD_M_ZERO_VALUE
                             : {1'b0, frac_q[`FD_M_HI:`FD_M_LO]};
    assign FRAC_N          = frac_q[`FD_N_HI:`FD_N_LO];

    // ==========================================================
    // Assertions
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence s_both_held;
        aw_have_q && w_have_q && !bvalid_q;
    endsequence
    sequence s_resp_up;
        BVALID ##1 (BVALID || $past(BREADY));
    endsequence

    a_write_resp_order: assert property (s_both_held |=> s_resp_up)
        else $error("write response did not follow address and data");
    a_carrier_delta: assert property ((lines[3] != lines_prev_q[3]) |=> delta_q[3])
        else $error("carrier change lost");
    a_ring_edge_flag: assert property ((lines[2] && !lines_prev_q[2]) |=> delta_q[2])
        else $error("ring rising edge lost");
    a_modem_read_clear: assert property ((modem_read && lines == lines_prev_q) |=> delta_q == 4'h0)
        else $error("delta flags not cleared by read");
    a_scratch_store: assert property ((do_write && wsel == SEL_SCRATCH && w_strb_q[0])
                                      |=> scratch_q == $past(w_data_q[7:0]))
        else $error("scratch write not stored");
    a_m_zero_four: assert property ((frac_q[`FD_M_HI:`FD_M_LO] == 2'h0)
                                    |-> FRAC_M == `FD_M_ZERO_VALUE)
        else $error("zero M field not read as four");
    a_parity_off: assert property (mode_on |-> !PARITY_CHECK_EN
                                   && (TX_NINE_BIT_EN == net_en_q[`NE_TX9_EN]))
        else $error("network mode gating wrong");
    a_driver_follow: assert property ((do_write && wsel == SEL_NET_ENABLE && w_strb_q[0])
                                      |=> SERIAL_OUT_OE == $past(w_data_q[`NE_DRIVER_EN]))
        else $error("driver enable not applied");
    a_match_flag_set: assert property (addr_hit |=> match_q ##1 (match_q || $past(RX_HOLD_READ)))
        else $error("address match not latched");
    a_line_first: assert property (line_q |-> ident[3:1] == `IC_LINE_STATUS && !ident[0])
        else $error("line status not given top priority");
    a_idle_ident: assert property ((delta_q == 4'h0 && !line_q && !rxf_q && !txe_q
                                    && !match_q && !sent_q) |-> ident == 8'h01)
        else $error("idle identification wrong");
    a_sent_clear: assert property ((sent_q && TX_HOLD_WRITE && !ADDR_SENT_EVT) |=> !sent_q)
        else $error("address-sent flag not cleared");

endmodule : uart_net_status
`default_nettype wire

// ---- testbench/net_node.sv ----
// Remote network node that sends received address frames
`timescale 1ns/1ps
`default_nettype none
module net_node
(
    input  wire logic       clk,
    output logic            vld,
    output logic [7:0]      adr
);
    initial
    begin
        vld = 1'b0;
        adr = 8'h00;
    end

    // Any of the 256 node addresses may be sent
    task automatic send(input logic [7:0] a);
        begin
            @(posedge clk);
            vld <= 1'b1;
            adr <= a;
            @(posedge clk);
            vld <= 1'b0;
            adr <= ~a;
        end
    endtask : send
endmodule : net_node
`default_nettype wire

// ---- testbench/test_uart_net_status.sv ----
// Self-checking bench for the UART network status block
`timescale 1ns/1ps
`default_nettype none
`include "uart_net_defs.svh"
module test_uart_net_status;
    import uart_net_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] awa, wd, ara, x, rdt;
    logic awv, wv, brdy, arv, rrdy, cd, ri, dsr, cts, lb, rts, dtr, a1, a2, txd, tp, sw;
    logic awr, wr, bv, arr, rv, rxv, so, soe, pce, t9, r9, w9, tam, fde, am, irq;
    logic [3:0] ev, cl;
    logic [1:0] br, rr;
    logic [2:0] fm;
    logic [10:0] fn;
    logic [7:0] rxb;
    logic [33:0] q[$];
    int seed = 32'h74C29AD1;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    localparam logic [7:0] rst_val [6] = '{8'h00, `RST_SCRATCH, `RST_NET_ENABLE, 8'h01,
        `RST_NODE_ADDRESS, 8'h00};
    localparam logic [15:0] irq_step [12] = '{16'h000C, 16'h1006, 16'h8006, 16'h010C,
        16'h020A, 16'h6004, 16'h020A, 16'h0801, 16'h4002, 16'h0401, 16'h1106, 16'h0101};

    always #12.5 clk = ~clk;

    uart_net_status dut (.REF_CLK(clk), .RST(rst), .AWADDR(awa), .AWVALID(awv), .AWREADY(awr),
        .WDATA(wd), .WSTRB(4'hF), .WVALID(wv), .WREADY(wr), .BRESP(br), .BVALID(bv),
        .BREADY(brdy), .ARADDR(ara), .ARVALID(arv), .ARREADY(arr), .RDATA(rdt), .RRESP(rr),
        .RVALID(rv), .RREADY(rrdy), .CARRIER_DETECT_IN(cd), .RING_IN(ri), .SET_READY_IN(dsr),
        .CLEAR_TO_SEND_IN(cts), .LOOPBACK_EN(lb), .REQ_TO_SEND_OUT(rts), .TERM_READY_OUT(dtr),
        .AUX1_OUT(a1), .AUX2_OUT(a2), .TX_SERIAL_DATA(txd), .RX_ADDR_VALID(rxv),
        .RX_ADDR_BYTE(rxb), .RX_HOLD_READ(cl[1]), .TX_HOLD_WRITE(cl[2]),
        .STD_IDENT_READ(cl[3]), .LINE_STATUS_READ(cl[0]), .LINE_STATUS_EVT(ev[0]),
        .RX_FULL_EVT(ev[1]), .TX_EMPTY_EVT(ev[2]), .ADDR_SENT_EVT(ev[3]), .SERIAL_OUT_O(so),
        .SERIAL_OUT_OE(soe), .PARITY_CHECK_EN(pce), .TX_NINE_BIT_EN(t9), .RX_NINE_BIT_EN(r9),
        .NINE_BIT_WORD(w9), .TX_ADDRESS_MARK(tam), .FRAC_DIV_EN(fde), .FRAC_M(fm),
        .FRAC_N(fn), .ADDR_MATCH(am), .NET_IRQ(irq));
    net_node node (.clk(clk), .vld(rxv), .adr(rxb));

    // ==========================================================
    // Shared tasks
    task automatic summarize;
        begin
            $display("checks %0d mismatches %0d", check_count, n_mismatch);
            if (n_mismatch == 0 && check_count > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask : summarize

    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        begin
            check_count++;
            if (s !== e)
            begin
                n_mismatch++;
                $display("wrong value at %0t: seen %h expected %h", $time, s, e);
            end
        end
    endtask : chk

    task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
        logic pa, pd;
        begin
            pa = 1'b1;
            pd = 1'b1;
            awa <= a;
            wd <= d;
            awv <= 1'b1;
            wv <= 1'b1;
            brdy <= 1'b1;
            while (pa | pd)
            begin
                @(posedge clk);
                if (awr) awv <= 1'b0;
                if (wr) wv <= 1'b0;
                pa = pa & ~awr;
                pd = pd & ~wr;
            end
            do @(posedge clk); while (bv !== 1'b1);
            brdy <= 1'b0;
            chk(br, e);
            @(posedge clk);
        end
    endtask : axw

    task automatic axr(input logic [31:0] a, input logic [33:0] e);
        begin
            q.push_back(e);
            ara <= a;
            arv <= 1'b1;
            rrdy <= 1'b1;
            do @(posedge clk); while (arr !== 1'b1);
            arv <= 1'b0;
            do @(posedge clk); while (rv !== 1'b1);
            rrdy <= 1'b0;
            @(posedge clk);
        end
    endtask : axr

    task automatic pl(input logic [3:0] e, input logic [3:0] c);
        begin
            ev <= e;
            cl <= c;
            @(posedge clk);
            ev <= 4'h0;
            cl <= 4'h0;
            @(posedge clk);
        end
    endtask : pl

    task automatic hit(input logic [7:0] a, input logic e);
        begin
            node.send(a);
            @(posedge clk);
            chk(am, e);
            @(posedge clk);
            chk(am, 1'b0);
        end
    endtask : hit

    // ==========================================================
    // Monitors and timeout
    always @(posedge clk)
    begin
        if (rv === 1'b1 && rrdy === 1'b1)
            chk({rr, rdt}, q.pop_front());
        if (sw) chk(so, tp);
        tp <= txd;
        txd <= $random(seed);
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_mismatch++;
            summarize;
        end
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        {awa, wd, ara, awv, wv, brdy, arv, rrdy, cd, ri, dsr, cts} = 0;
        {lb, rts, dtr, a1, a2, txd, tp, sw, ev, cl} = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 6; i++) axr(`ADDR_MODEM_STATUS + 4 * i, {26'h0, rst_val[i]});
        axr(32'hFFFF0730, {`RESP_SLVERR, 32'h0});
        x = $random(seed);
        axw(`ADDR_SCRATCH, x, `RESP_OKAY);
        axw(`ADDR_NET_IDENT, x, `RESP_OKAY);
        axw(32'hFFFF0730, x, `RESP_SLVERR);
        axr(`ADDR_SCRATCH, {26'h0, x[7:0]});
        axr(`ADDR_NET_IDENT, 34'h1);
        for (int m = 0; m < 4; m++)
        begin
            x = $random(seed);
            x[14:11] = 4'(m);
            axw(`ADDR_FRAC_DIVIDER, x, `RESP_OKAY);
            chk(fde, x[15]);
            chk(fm, (m == 0) ? 3'h4 : 3'(m));
            chk(fn, x[10:0]);
            axr(`ADDR_FRAC_DIVIDER, {18'h0, x[15:0]});
        end
        $display("test done: registers");
        for (int i = 0; i < 8; i++)
        begin
            x = $random(seed);
            x[6:5] = x[6:5] & {2{x[7]}};
            x[6] = x[6] & ~x[3];
            axw(`ADDR_SCRATCH, x >> 8, `RESP_OKAY);
            axw(`ADDR_NET_ENABLE, x, `RESP_OKAY);
            chk(pce, !x[7]);
            chk(t9, x[7] & x[6]);
            chk(r9, x[7] & x[5]);
            chk(w9, x[3]);
            chk(soe, x[2]);
            chk(tam, x[7] & (x[8] | x[0]));
            chk(irq, !x[1]);
            axr(`ADDR_NET_ENABLE, {26'h0, x[7:0]});
        end
        sw <= 1'b1;
        repeat (20) @(posedge clk);
        sw <= 1'b0;
        $display("test done: network enable");
        cts <= 1'b1;
        repeat (6) @(posedge clk);
        axr(`ADDR_MODEM_STATUS, 34'h11);
        axr(`ADDR_MODEM_STATUS, 34'h10);
        ri <= 1'b1;
        repeat (6) @(posedge clk);
        axr(`ADDR_MODEM_STATUS, 34'h54);
        {ri, cd, dsr} <= 3'b011;
        repeat (6) @(posedge clk);
        axr(`ADDR_NET_IDENT, 34'h0);
        axr(`ADDR_MODEM_STATUS, 34'hBA);
        axr(`ADDR_NET_IDENT, 34'h1);
        {rts, dtr, a2} <= 3'b111;
        @(posedge clk);
        {lb, a1, cts} <= 3'b110;
        repeat (6) @(posedge clk);
        chk(so, 1'b1);
        axr(`ADDR_MODEM_STATUS, 34'hF4);
        cts <= 1'b1;
        repeat (6) @(posedge clk);
        lb <= 1'b0;
        repeat (6) @(posedge clk);
        axr(`ADDR_MODEM_STATUS, 34'hB0);
        $display("test done: modem lines");
        x = $random(seed);
        axw(`ADDR_NODE_ADDRESS, x, `RESP_OKAY);
        axw(`ADDR_NET_ENABLE, 32'hB6, `RESP_OKAY);
        chk(irq, 1'b0);
        hit(~x[7:0], 1'b0);
        hit(x[7:0], 1'b1);
        for (int i = 0; i < 12; i++)
        begin
            pl(irq_step[i][15:12], irq_step[i][11:8]);
            axr(`ADDR_NET_IDENT, {26'h0, irq_step[i][7:0]});
            chk(irq, !irq_step[i][0]);
        end
        $display("test done: interrupts");
        summarize;
    end
endmodule : test_uart_net_status
`default_nettype wire
